// File: src/sp_defs.vh
// Constants for the serial-to-parallel latch block
`ifndef SP_DEFS_VH
`define SP_DEFS_VH

`define SP_CHAIN_W      8
`define SP_FIFO_DEPTH   16
`define SP_FIFO_CNT_W   5
`define SP_CHAIN_RST    8'h00
`define SP_STORE_RST    8'h00
`define SP_OE_RST       8'h00
`define SP_SYNC_RST     2'h0
`define SP_CNT_RST      5'h00
`define SP_CLEAR_IDLE   2'h3
`define SP_OE_IDLE      2'h3

`endif

// File: src/sp_latch.v
// Serial-to-parallel shift chain with storage register and snapshot FIFO
`timescale 1ns/1ps
`include "sp_defs.vh"

// -----------------------------------------------------------------------
// Shift-register FIFO, head entry is a flop
// -----------------------------------------------------------------------
module sp_fifo #(
  parameter WIDTH = `SP_CHAIN_W,
  parameter DEPTH = `SP_FIFO_DEPTH,
  parameter CNT_W = `SP_FIFO_CNT_W
) (
  input  wire             i_sys_clk,
  input  wire             i_rst_n,
  input  wire [WIDTH-1:0] i_in_data,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  output wire [WIDTH-1:0] o_out_data,
  output wire             o_out_valid,
  input  wire             i_out_ready
);

  reg  [WIDTH-1:0] mem_r [0:DEPTH];
  reg  [CNT_W-1:0] cnt_r;
  reg              full_r;
  reg              valid_r;
  wire             push;
  wire             pop;
  wire [CNT_W-1:0] slot;
  wire [CNT_W-1:0] cnt_nxt;

  localparam [CNT_W-1:0] FULL_CNT = DEPTH;

  // Full is a flop so back-pressure reaches the writer without a long path
  assign o_in_ready  = ~full_r;
  assign o_out_data  = mem_r[0];
  assign o_out_valid = valid_r;
  assign push        = i_in_valid & ~full_r;
  assign pop         = i_out_ready & valid_r;
  assign slot        = pop ? cnt_r - 1'b1 : cnt_r;
  assign cnt_nxt     = cnt_r + {{(CNT_W-1){1'b0}}, push}
                             - {{(CNT_W-1){1'b0}}, pop};

  // Spare top slot always reads zero so the shift has a source
  always @(posedge i_sys_clk) begin
    mem_r[DEPTH] <= {WIDTH{1'b0}};
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_entry
      localparam [CNT_W-1:0] IDX = g;
      always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          mem_r[g] <= {WIDTH{1'b0}};
        end else if (push && (slot == IDX)) begin
          mem_r[g] <= i_in_data;
        end else if (pop) begin
          mem_r[g] <= mem_r[g+1];
        end
      end
    end
  endgenerate

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_r   <= `SP_CNT_RST;
      full_r  <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      full_r  <= (cnt_nxt == FULL_CNT);
      valid_r <= (cnt_nxt != {CNT_W{1'b0}});
    end
  end

endmodule // sp_fifo

// -----------------------------------------------------------------------
// Top: pin synchronisers, chain, storage, three-state drive
// -----------------------------------------------------------------------
module sp_latch (
  input  wire                   i_sys_clk,
  input  wire                   i_rst_n,
  input  wire                   i_serial_in,
  input  wire                   i_shift_clock,
  input  wire                   i_latch_clock,
  input  wire                   i_chain_clear_n,
  input  wire                   i_out_enable_n,
  output reg                    o_serial_out,
  output reg  [`SP_CHAIN_W-1:0] o_parallel_out,
  output reg  [`SP_CHAIN_W-1:0] o_parallel_oe,
  output wire [`SP_CHAIN_W-1:0] o_snap_data,
  output wire                   o_snap_valid,
  input  wire                   i_snap_ready,
  output reg                    o_snap_overrun
);

  // -----------------------------------------------------------------------
  // Synchronisers: first stage read only by the second
  // -----------------------------------------------------------------------
  reg  [1:0]             din_s_r;
  reg  [1:0]             shc_s_r;
  reg  [1:0]             ltc_s_r;
  reg  [1:0]             clr_s_r;
  reg  [1:0]             oen_s_r;
  reg                    shc_d_r;
  reg                    ltc_d_r;
  reg  [`SP_CHAIN_W-1:0] chain_r;
  reg  [`SP_CHAIN_W-1:0] chain_nxt;
  reg  [`SP_CHAIN_W-1:0] store_nxt;
  wire                   shift_rise;
  wire                   latch_rise;
  wire                   clear_act;
  wire                   fifo_ready;

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      din_s_r <= `SP_SYNC_RST;
      shc_s_r <= `SP_SYNC_RST;
      ltc_s_r <= `SP_SYNC_RST;
      clr_s_r <= `SP_CLEAR_IDLE;
      oen_s_r <= `SP_OE_IDLE;
      shc_d_r <= 1'b0;
      ltc_d_r <= 1'b0;
    end else begin
      din_s_r <= {din_s_r[0], i_serial_in};
      shc_s_r <= {shc_s_r[0], i_shift_clock};
      ltc_s_r <= {ltc_s_r[0], i_latch_clock};
      clr_s_r <= {clr_s_r[0], i_chain_clear_n};
      oen_s_r <= {oen_s_r[0], i_out_enable_n};
      shc_d_r <= shc_s_r[1];
      ltc_d_r <= ltc_s_r[1];
    end
  end

  assign shift_rise = shc_s_r[1] & ~shc_d_r;
  assign latch_rise = ltc_s_r[1] & ~ltc_d_r;
  assign clear_act  = ~clr_s_r[1];

  // -----------------------------------------------------------------------
  // Chain and storage next values
  // -----------------------------------------------------------------------
  // Clear is level sensitive after sync; it holds the chain at zero for as
  // long as it stays low, two cycles late against the pin.
  always @* begin
    chain_nxt = chain_r;
    store_nxt = o_parallel_out;
    if (clear_act) begin
      chain_nxt = `SP_CHAIN_RST;
    end else if (shift_rise) begin
      chain_nxt = {chain_r[`SP_CHAIN_W-2:0], din_s_r[1]};
    end
    if (latch_rise) begin
      if (clear_act) begin
        store_nxt = `SP_STORE_RST;
      end else begin
        store_nxt = chain_r;
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      chain_r        <= `SP_CHAIN_RST;
      o_serial_out   <= 1'b0;
      o_parallel_out <= `SP_STORE_RST;
      o_parallel_oe  <= `SP_OE_RST;
      o_snap_overrun <= 1'b0;
    end else begin
      chain_r        <= chain_nxt;
      // Top stage, i.e. old stage six after a shift; driven always
      o_serial_out   <= chain_nxt[`SP_CHAIN_W-1];
      o_parallel_out <= store_nxt;
      // Enable only gates drive, never the stored data
      o_parallel_oe  <= {`SP_CHAIN_W{~oen_s_r[1]}};
      // Storage still loads when the FIFO is full; only the copy is lost
      o_snap_overrun <= latch_rise & ~fifo_ready;
    end
  end

  // -----------------------------------------------------------------------
  // Snapshot FIFO of every storage load that finds it not full
  // -----------------------------------------------------------------------
  sp_fifo #(
    .WIDTH (`SP_CHAIN_W),
    .DEPTH (`SP_FIFO_DEPTH),
    .CNT_W (`SP_FIFO_CNT_W)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_in_data   (store_nxt),
    .i_in_valid  (latch_rise),
    .o_in_ready  (fifo_ready),
    .o_out_data  (o_snap_data),
    .o_out_valid (o_snap_valid),
    .i_out_ready (i_snap_ready)
  );

endmodule // sp_latch

// File: verification/sp_checker.sv
// Port checker for the serial-to-parallel latch
`timescale 1ns/1ps
module sp_checker (
  input logic       i_sys_clk,
  input logic       i_rst_n,
  input logic       i_serial_in,
  input logic       i_shift_clock,
  input logic       i_latch_clock,
  input logic       i_chain_clear_n,
  input logic       i_out_enable_n,
  input logic       o_serial_out,
  input logic [7:0] o_parallel_out,
  input logic [7:0] o_parallel_oe,
  input logic [7:0] o_snap_data,
  input logic       o_snap_valid,
  input logic       i_snap_ready,
  input logic       o_snap_overrun
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  property p_on; (!i_out_enable_n)[*4] |-> &o_parallel_oe; endproperty
  a_on: assert property (p_on) else $error("oe off");
  property p_off; i_out_enable_n[*4] |-> o_parallel_oe == 0; endproperty
  a_off: assert property (p_off) else $error("oe on");
  property p_clr; (!i_chain_clear_n)[*4] |-> !o_serial_out; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_st; $changed(o_parallel_out) |-> $past(i_latch_clock, 3)
    && !$past(i_latch_clock, 4); endproperty
  a_st: assert property (p_st) else $error("store");
  property p_so; $changed(o_serial_out) |-> $past(i_shift_clock, 3)
    && !$past(i_shift_clock, 4) || !$past(i_chain_clear_n, 3); endproperty
  a_so: assert property (p_so) else $error("serial");
  property p_zl; (!i_chain_clear_n)[*3] ##1 $rose(i_latch_clock)
    && !i_chain_clear_n |-> ##3 o_parallel_out == 0; endproperty
  a_zl: assert property (p_zl) else $error("zero load");
  property p_hold; o_snap_valid && !i_snap_ready |=> o_snap_valid
    && $stable(o_snap_data); endproperty
  a_hold: assert property (p_hold) else $error("head"); // Buffer holds
  property p_ovr; o_snap_overrun |-> o_snap_valid; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun"); // Buffer not empty on overrun
  c_both: cover property ($rose(i_shift_clock) && $rose(i_latch_clock));
  c_ovr: cover property (o_snap_overrun);
  c_zl: cover property ($rose(i_latch_clock) && !i_chain_clear_n);
endmodule // sp_checker
bind sp_latch sp_checker chk_u (.*);

// File: verification/sp_host.sv
// Host model driving the latch block's pins
`timescale 1ns/1ps
module sp_host (
  input  wire  i_clk,
  output logic o_sd,
  output logic o_sh,
  output logic o_la,
  output logic o_clr_n,
  output logic o_oe_n
);
  initial {o_sd, o_sh, o_la, o_clr_n, o_oe_n} = 5'h03;
  // Clocks rest low between pulses, as shared by cascaded parts
  task pulse(input logic s, l, d);
    o_sd <= d;
    repeat (3) @(posedge i_clk);
    o_sh <= s;
    o_la <= l;
    repeat (4) @(posedge i_clk);
    o_sh <= 1'h0;
    o_la <= 1'h0;
    o_sd <= ~d; // Stale data must not pass
    repeat (4) @(posedge i_clk);
  endtask
  task ctl(input logic c, e);
    o_clr_n <= c;
    o_oe_n <= e;
    repeat (5) @(posedge i_clk);
  endtask
endmodule // sp_host

// File: verification/tb_top.sv
// Self-checking testbench for the latch block
`timescale 1ns/1ps
module tb_top;
  logic i_sys_clk = 0, i_rst_n = 0, i_snap_ready = 1, ovr_seen = 0;
  logic i_serial_in, i_shift_clock, i_latch_clock, i_chain_clear_n;
  logic i_out_enable_n, o_serial_out, o_snap_valid, o_snap_overrun;
  logic [7:0] o_parallel_out, o_parallel_oe, o_snap_data;
  int   bad_count = 0;
  int   n_tests = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (o_snap_overrun === 1'b1) ovr_seen <= 1;
  sp_host host_u (.i_clk(i_sys_clk), .o_sd(i_serial_in),
    .o_sh(i_shift_clock), .o_la(i_latch_clock),
    .o_clr_n(i_chain_clear_n), .o_oe_n(i_out_enable_n));
  sp_latch dut_u (.*);
  task chk(input logic [7:0] g, e);
    #1;
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wrap_up;
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task send(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) host_u.pulse(1'h1, 1'h0, v[i]);
  endtask
  task t_load;
    send(8'hA5);
    host_u.pulse(1'h0, 1'h1, 1'h0);
    host_u.ctl(1'h1, 1'h0);
    chk(o_parallel_out, 8'hA5);
    chk(o_parallel_oe, 8'hFF);
    chk(o_serial_out, 8'h01);
  endtask
  task t_both;
    host_u.pulse(1'h1, 1'h1, 1'h0);
    chk(o_parallel_out, 8'hA5);
    chk(o_serial_out, 8'h00);
    host_u.pulse(1'h0, 1'h1, 1'h0);
    chk(o_parallel_out, 8'h4A);
  endtask
  task t_oe;
    host_u.ctl(1'h1, 1'h1);
    chk(o_parallel_oe, 8'h00);
    host_u.pulse(1'h1, 1'h0, 1'h0);
    host_u.ctl(1'h1, 1'h0);
    chk(o_parallel_out, 8'h4A);
    chk(o_serial_out, 8'h01);
  endtask
  task t_clr;
    host_u.ctl(1'h0, 1'h1);
    chk(o_serial_out, 8'h00);
    chk(o_parallel_oe, 8'h00);
    host_u.ctl(1'h0, 1'h0);
    chk(o_parallel_out, 8'h4A);
    host_u.pulse(1'h1, 1'h1, 1'h1);
    chk(o_parallel_out, 8'h00);
    chk(o_serial_out, 8'h00);
    host_u.ctl(1'h1, 1'h0);
  endtask
  task t_fifo;
    int n;
    n = 0;
    send(8'h3C);
    i_snap_ready <= 0;
    repeat (17) host_u.pulse(1'h0, 1'h1, 1'h0);
    chk(ovr_seen, 8'h01); // Lost copy flagged
    @(posedge i_sys_clk);
    i_snap_ready <= 1;
    repeat (40) begin
      #1;
      if (o_snap_valid === 1'b1 && o_snap_data === 8'h3C) n++;
      @(posedge i_sys_clk);
    end
    chk(n, 8'h10); // Sixteen words kept
  endtask
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1;
    repeat (3) @(posedge i_sys_clk);
    t_load;
    t_both;
    t_oe;
    t_clr;
    t_fifo;
    wrap_up;
  end
endmodule // tb_top
